/* File: design/sda_alu.sv */
// Saturating DSP ALU: decode, two-stage pipeline and guarded write-back
//
// Operation
// - Word abs treats source signed; most negative yields 0x7FFFFFFF.
// - Word abs runs as two-operand form: zero first, value second.
// - Word add sign-extends, adds, clips to 0x80000000 or 0x7FFFFFFF.
// - Dual abs per signed half; 0x8000 gives 0x7FFF; result 0 to 0x7FFF.
// - Dual abs upper half goes to bits 31:16, lower to 15:0.
// - Dual abs runs as two-operand form: zero first, pair second.
// - Dual add per half, no carry between, clipped 0x8000 to 0x7FFF.
// - With guard, write destination only when guard bit 0 is 1.
// - Without guard, write the result whenever the opcode is known and the slot is 1 or 3.
`timescale 1ns/10ps
module sda_alu #(
    parameter int LATENCY = sda_pkg::LATENCY
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic issue_valid,
    input wire logic [7:0] opcode,
    input wire logic [2:0] issue_slot,
    input wire logic [31:0] first_source,
    input wire logic [31:0] second_source,
    input wire logic guard_present,
    input wire logic [31:0] guard_value,
    input wire logic [4:0] dest_index,
    output logic write_enable,
    output logic [4:0] write_index,
    output logic [31:0] write_data,
    output logic issue_reject
);
    // Only the two-register pipeline below exists, so no other depth can be served
    if (LATENCY != sda_pkg::LATENCY)
    begin : g_latency_check
        $error("sda_alu supports only the two-cycle latency");
    end

    logic rst_meta;
    logic rst_sync;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    logic known_op;
    logic slot_ok;
    logic [1:0] dec_op;
    logic [31:0] core_a;
    logic [31:0] core_b;
    always_comb
    begin
        known_op = 1'b1;
        dec_op = sda_pkg::SDA_OP_WORD_ABS;
        unique case (opcode)
            sda_pkg::OPC_WORD_ABS: dec_op = sda_pkg::SDA_OP_WORD_ABS;
            sda_pkg::OPC_WORD_ADD: dec_op = sda_pkg::SDA_OP_WORD_ADD;
            sda_pkg::OPC_DUAL_ABS: dec_op = sda_pkg::SDA_OP_DUAL_ABS;
            sda_pkg::OPC_DUAL_ADD: dec_op = sda_pkg::SDA_OP_DUAL_ADD;
            default: known_op = 1'b0;
        endcase
        // only slots 1 and 3 issue here
        slot_ok = (issue_slot == sda_pkg::SLOT_LOW) || (issue_slot == sda_pkg::SLOT_HIGH);
        // abs forms get zero first, source second
        // same mapping for the halfword pair
        if (opcode == sda_pkg::OPC_WORD_ABS || opcode == sda_pkg::OPC_DUAL_ABS)
        begin
            core_a = sda_pkg::ZERO_WORD;
            core_b = first_source;
        end
        else
        begin
            core_a = first_source;
            core_b = second_source;
        end
    end

    logic [31:0] core_result;
    sda_core sda_core_inst (
        .op(dec_op),
        .first_source(core_a),
        .second_source(core_b),
        .result(core_result)
    );

    // Stage 1 holds the result; stage 2 presents it, giving two cycles
    logic s1_valid;
    logic [4:0] s1_index;
    logic [31:0] s1_data;
    logic next_s1_valid;
    logic next_write_enable;
    logic next_reject;
    always_comb
    begin
        // guard bit 0 gates the write
        next_s1_valid = issue_valid && known_op && slot_ok &&
                        (!guard_present || guard_value[0]);
        next_reject = issue_valid && !(known_op && slot_ok);
        next_write_enable = s1_valid;
    end

    always_ff @(posedge clk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            s1_valid <= 1'b0;
            s1_index <= sda_pkg::DEST_RESET;
            s1_data <= sda_pkg::ZERO_WORD;
            write_enable <= 1'b0;
            write_index <= sda_pkg::DEST_RESET;
            write_data <= sda_pkg::ZERO_WORD;
            issue_reject <= 1'b0;
        end
        else
        begin
            s1_valid <= next_s1_valid;
            s1_index <= dest_index;
            s1_data <= core_result;
            write_enable <= next_write_enable;
            write_index <= s1_index;
            write_data <= s1_data;
            issue_reject <= next_reject;
        end
    end

    sequence s_good_issue;
        issue_valid && known_op && slot_ok && (!guard_present || guard_value[0]);
    endsequence

    a_latency_two: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue |-> ##2 write_enable)
        else $error("write not seen two cycles after issue");
    a_guard_blocks: assert property (@(posedge clk) disable iff (!rst_sync)
        issue_valid && guard_present && !guard_value[0] |-> ##2 !write_enable)
        else $error("false guard still wrote");
    a_no_guard_writes: assert property (@(posedge clk) disable iff (!rst_sync)
        issue_valid && known_op && slot_ok && !guard_present |-> ##2 write_enable)
        else $error("unguarded op did not write");
    a_bad_slot: assert property (@(posedge clk) disable iff (!rst_sync)
        issue_valid && !slot_ok |-> ##1 issue_reject ##1 !write_enable)
        else $error("wrong slot not rejected");
    a_word_abs_clip: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ABS && first_source == sda_pkg::WORD_MIN
        |-> ##2 write_data == sda_pkg::WORD_MAX)
        else $error("word abs minimum not clipped");
    a_word_abs_pos: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ABS && !first_source[31]
        |-> ##2 write_data == $past(first_source, 2))
        else $error("word abs changed a positive value");
    a_word_add_range: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ADD && !first_source[31]
        && !second_source[31] |-> ##2 !write_data[31])
        else $error("positive add overflowed sign");
    a_word_add_low: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ADD && first_source[31]
        && second_source[31] |-> ##2 write_data[31])
        else $error("negative add wrapped positive");
    a_dual_abs_range: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ABS
        |-> ##2 !write_data[31] && !write_data[15])
        else $error("dual abs half out of range");
    a_dual_abs_place: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ABS && !first_source[31]
        |-> ##2 write_data[31:16] == $past(first_source[31:16], 2))
        else $error("dual abs upper half misplaced");
    a_dual_add_split: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ADD && first_source[15:0] == 16'hFFFF
        && second_source[15:0] == 16'h0001 && second_source[31:16] == 16'h0000
        |-> ##2 write_data == {$past(first_source[31:16], 2), 16'h0000})
        else $error("carry leaked between halves");
    a_bad_opcode: assert property (@(posedge clk) disable iff (!rst_sync)
        issue_valid && !known_op |-> ##1 issue_reject ##1 !write_enable)
        else $error("unknown opcode not rejected");

    // Value checks compare against the operands sampled at the issue edge
    a_word_abs_neg: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ABS && first_source[31]
        && first_source != sda_pkg::WORD_MIN |-> ##2 write_data == -$past(first_source, 2))
        else $error("negative word abs not negated");
    a_word_add_exact: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ADD
        && first_source[31] != second_source[31]
        |-> ##2 write_data == $past(first_source, 2) + $past(second_source, 2))
        else $error("mixed-sign add not exact");
    a_word_add_high: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_WORD_ADD && !first_source[31]
        && !second_source[31] && first_source[30] && second_source[30]
        |-> ##2 write_data == sda_pkg::WORD_MAX)
        else $error("positive add overflow not clipped");
    a_dual_abs_min: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ABS
        && first_source[31:16] == sda_pkg::HALF_MIN
        |-> ##2 write_data[31:16] == sda_pkg::HALF_MAX)
        else $error("half minimum not clipped");
    a_dual_abs_low: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ABS && !first_source[15]
        |-> ##2 write_data[15:0] == $past(first_source[15:0], 2))
        else $error("dual abs did not take its value from the only operand");
    a_dual_add_high: assert property (@(posedge clk) disable iff (!rst_sync)
        s_good_issue and opcode == sda_pkg::OPC_DUAL_ADD && !first_source[15]
        && !second_source[15] && first_source[14] && second_source[14]
        |-> ##2 write_data[15:0] == sda_pkg::HALF_MAX)
        else $error("lower half add overflow not clipped");
    a_index_carry: assert property (@(posedge clk) disable iff (!rst_sync)
        write_enable |-> write_index == $past(dest_index, 2))
        else $error("write went to the wrong register");
    a_reject_cause: assert property (@(posedge clk) disable iff (!rst_sync)
        issue_reject |-> $past(issue_valid))
        else $error("reject without an issue");
endmodule

/* File: design/sda_pkg.sv */
// Package: opcodes, widths, saturation limits and latency for the clipped DSP ALU
package sda_pkg;
    localparam int DATA_W = 32;
    localparam int HALF_W = 16;
    localparam int OPC_W = 8;
    localparam int SLOT_W = 3;
    localparam int LATENCY = 2;
    localparam logic [7:0] OPC_WORD_ABS = 8'h41;
    localparam logic [7:0] OPC_WORD_ADD = 8'h42;
    localparam logic [7:0] OPC_DUAL_ADD = 8'h46;
    localparam logic [7:0] OPC_DUAL_ABS = 8'h48;
    localparam logic [2:0] SLOT_LOW = 3'h1;
    localparam logic [2:0] SLOT_HIGH = 3'h3;
    localparam logic [31:0] WORD_MAX = 32'h7FFFFFFF;
    localparam logic [31:0] WORD_MIN = 32'h80000000;
    localparam logic [15:0] HALF_MAX = 16'h7FFF;
    localparam logic [15:0] HALF_MIN = 16'h8000;
    localparam logic [31:0] ZERO_WORD = 32'h00000000;
    localparam logic [4:0] DEST_RESET = 5'h00;
    typedef enum logic [1:0] {
        SDA_OP_WORD_ABS = 2'h0,
        SDA_OP_WORD_ADD = 2'h1,
        SDA_OP_DUAL_ADD = 2'h3,
        SDA_OP_DUAL_ABS = 2'h2
    } sda_op_t;
endpackage

/* File: design/sda_core.sv */
// Combinational two-operand clipped arithmetic core
`timescale 1ns/10ps
module sda_core (
    input wire logic [1:0] op,
    input wire logic [31:0] first_source,
    input wire logic [31:0] second_source,
    output logic [31:0] result
);
    function automatic logic [15:0] sat_add16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} + {b[15], b};
        if (s[16] != s[15])
            sat_add16 = s[16] ? sda_pkg::HALF_MIN : sda_pkg::HALF_MAX;
        else
            sat_add16 = s[15:0];
    endfunction

    // Zero minus the value, clipped; the minimum maps to the maximum
    function automatic logic [15:0] sat_sub16(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {a[15], a} - {b[15], b};
        if (s[16] != s[15])
            sat_sub16 = s[16] ? sda_pkg::HALF_MIN : sda_pkg::HALF_MAX;
        else
            sat_sub16 = s[15:0];
    endfunction

    logic [32:0] wsum;
    logic [32:0] wdif;
    always_comb
    begin
        wsum = {first_source[31], first_source} + {second_source[31], second_source};
        wdif = {first_source[31], first_source} - {second_source[31], second_source};
        result = sda_pkg::ZERO_WORD;
        unique case (op)
            sda_pkg::SDA_OP_WORD_ABS:
            begin
                if (!second_source[31])
                    result = second_source;
                else if (wdif[32] != wdif[31])
                    result = sda_pkg::WORD_MAX;
                else
                    result = wdif[31:0];
            end
            sda_pkg::SDA_OP_WORD_ADD:
            begin
                if (wsum[32] != wsum[31])
                    result = wsum[32] ? sda_pkg::WORD_MIN : sda_pkg::WORD_MAX;
                else
                    result = wsum[31:0];
            end
            sda_pkg::SDA_OP_DUAL_ADD:
            begin
                result = {sat_add16(first_source[31:16], second_source[31:16]),
                          sat_add16(first_source[15:0], second_source[15:0])};
            end
            sda_pkg::SDA_OP_DUAL_ABS:
            begin
                result[31:16] = second_source[31] ?
                    sat_sub16(first_source[31:16], second_source[31:16]) :
                    second_source[31:16];
                result[15:0] = second_source[15] ?
                    sat_sub16(first_source[15:0], second_source[15:0]) :
                    second_source[15:0];
            end
        endcase
    end
endmodule

/* File: verification/sda_regfile_model.sv */
// Register-file partner model that collects the ALU's write-backs
`timescale 1ns/10ps
module sda_regfile_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic write_enable,
    input wire logic [4:0] write_index,
    input wire logic [31:0] write_data,
    output logic [31:0] regs [32]
);
    // Outside reset, entries only change on a write pulse, so a suppressed write leaves them intact
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 32; i++)
                regs[i] <= 32'h00000000;
        end
        else if (write_enable)
            regs[write_index] <= write_data;
    end
endmodule

/* File: verification/sda_alu_test.sv */
// Self-checking testbench of the clipped DSP ALU
`timescale 1ns/10ps
module sda_alu_test;
    typedef struct packed {logic rej; logic [4:0] idx; logic [31:0] data;} sda_exp_t;
    logic clk = 1'b0, rst_n = 1'b0, issue_valid = 1'b0, guard_present = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic [2:0] issue_slot = 3'h1;
    logic [31:0] first_source = 32'h0, second_source = 32'h0, guard_value = 32'h0;
    logic [4:0] dest_index = 5'h00, write_index;
    logic write_enable, issue_reject;
    logic [31:0] write_data;
    logic [31:0] regs [32];
    logic [31:0] shadow [32];
    logic [7:0] opcs [4] = '{8'h41, 8'h42, 8'h48, 8'h46};
    logic [31:0] va [12] = '{32'hFFFFFFFF, 32'h80000001, 32'h80000000, 32'h00001200,
        32'h7FFFFFFF, 32'h80000000, 32'hFFFF0032, 32'h80008001, 32'h7FFFFFFF,
        32'h12340032, 32'h80000001, 32'h00017FFF};
    logic [31:0] vb [12] = '{32'h5, 32'h6, 32'h7, 32'hFF, 32'h1, 32'hFFFFFFFF, 32'h9,
        32'hA, 32'hB, 32'h00010002, 32'hFFFF7FFF, 32'h7FFF7FFF};
    sda_exp_t q [$];
    int failures = 0, cmp_count = 0, seed = 43;

    always #4 clk = ~clk;

    sda_alu sda_alu_inst (.clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
        .opcode(opcode), .issue_slot(issue_slot), .first_source(first_source),
        .second_source(second_source), .guard_present(guard_present),
        .guard_value(guard_value), .dest_index(dest_index), .write_enable(write_enable),
        .write_index(write_index), .write_data(write_data), .issue_reject(issue_reject));
    sda_regfile_model sda_regfile_model_inst (.clk(clk), .rst_n(rst_n),
        .write_enable(write_enable), .write_index(write_index), .write_data(write_data),
        .regs(regs));

    function automatic logic [15:0] c16(logic [16:0] x);
        return (x[16] != x[15]) ? (x[16] ? sda_pkg::HALF_MIN : sda_pkg::HALF_MAX) : x[15:0];
    endfunction
    function automatic logic [15:0] a16(logic [15:0] x);
        return x[15] ? ((x == sda_pkg::HALF_MIN) ? sda_pkg::HALF_MAX : -x) : x;
    endfunction
    function automatic logic [31:0] model(logic [7:0] o, logic [31:0] a, logic [31:0] b);
        logic [32:0] s;
        s = {a[31], a} + {b[31], b};
        if (o == sda_pkg::OPC_WORD_ABS)
            return a[31] ? ((a == sda_pkg::WORD_MIN) ? sda_pkg::WORD_MAX : -a) : a;
        if (o == sda_pkg::OPC_WORD_ADD)
            return (s[32] != s[31]) ? (s[32] ? sda_pkg::WORD_MIN : sda_pkg::WORD_MAX) : s[31:0];
        if (o == sda_pkg::OPC_DUAL_ABS)
            return {a16(a[31:16]), a16(a[15:0])};
        return {c16({a[31], a[31:16]} + {b[31], b[31:16]}), c16({a[15], a[15:0]} + {b[15], b[15:0]})};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test;
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic issue(input logic [7:0] o, input logic [2:0] sl, input logic [31:0] a,
        input logic [31:0] b, input logic gp, input logic g0, input logic [4:0] d);
        logic ok;
        ok = (sl == sda_pkg::SLOT_LOW || sl == sda_pkg::SLOT_HIGH) && (o inside {opcs});
        @(posedge clk);
        #1;
        {issue_valid, opcode, issue_slot, first_source, second_source} = {1'b1, o, sl, a, b};
        {guard_present, guard_value, dest_index} = {gp, $random(seed) & ~32'h1 | g0, d};
        if (!ok)
            q.push_back('{1'b1, 5'h00, 32'h0});
        else if (!gp || g0)
        begin
            q.push_back('{1'b0, d, model(o, a, b)});
            shadow[d] = model(o, a, b);
        end
    endtask

    // Results leave in issue order, a reject never before an older write
    always @(negedge clk)
    begin
        for (int k = 0; k < 2; k++)
        begin
            if ((k == 0 ? write_enable : issue_reject) === 1'b1)
            begin
                check("pending", q.size() > 0, 1);
                if (q.size() > 0)
                begin
                    check("kind", q[0].rej, k);
                    if (k == 0)
                        check("index", write_index, q[0].idx);
                    if (k == 0)
                        check("data", write_data, q[0].data);
                    void'(q.pop_front());
                end
            end
        end
    end

    initial
    begin
        #(8 * 5000);
        failures++;
        end_of_test();
    end

    initial
    begin
        foreach (shadow[i])
            shadow[i] = 32'h0;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 12; i++)
            issue(opcs[i / 3], 3'h1, va[i], vb[i], 1'b0, 1'b0, 5'(i + 1));
        // Carry must not cross halves; a false guard must leave its register alone
        issue(sda_pkg::OPC_DUAL_ADD, 3'h3, 32'h1234FFFF, 32'h00000001, 1'b1, 1'b1, 5'h1F);
        issue(sda_pkg::OPC_WORD_ADD, 3'h3, 32'h00001200, 32'h000000FF, 1'b1, 1'b0, 5'h1E);
        @(posedge clk);
        #1;
        issue_valid = 1'b0;
        repeat (3) @(posedge clk);
        check("drained", q.size(), 0);
        // Mid-run reset: write_index and write_data still hold the blocked add's 0x1E and 0x12FF, so zero is a real change there
        #1;
        rst_n = 1'b0;
        @(negedge clk);
        check("reset enable", write_enable, 1'b0);
        check("reset reject", issue_reject, 1'b0);
        check("reset index", write_index, 5'h00);
        check("reset data", write_data, 32'h0);
        foreach (shadow[i])
            shadow[i] = 32'h0;
        @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 400; i++)
        begin
            if ($random(seed) % 5 == 0)
            begin
                @(posedge clk);
                #1;
                issue_valid = 1'b0;
            end
            issue(($random(seed) % 9 == 0) ? 8'h47 : opcs[$unsigned($random(seed)) % 4],
                ($random(seed) % 7 == 0) ? 3'h2 : ($random(seed) & 1 ? 3'h3 : 3'h1),
                $random(seed), $random(seed), 1'($random(seed)), 1'($random(seed)),
                5'($random(seed)));
        end
        @(posedge clk);
        #1;
        issue_valid = 1'b0;
        repeat (4) @(posedge clk);
        check("drained", q.size(), 0);
        for (int i = 0; i < 32; i++)
            check("register", regs[i], shadow[i]);
        end_of_test();
    end
endmodule
